// *** rtl/echo_ctrl_pkg.sv ***
// Notes on behaviour
// - Writing zero to a group's power-up bit powers down both cancellers of it.
// - Powered-down group passes receive and send data through, two frames late.
// - Each canceller interrupts at tone-disable start and again at release.
// - Every pending interrupt is queued as its channel number in a FIFO.
// - Request pin returns high after every read of the interrupt FIFO register.
// - Request pin goes low again for each entry still queued.
// - Status register holds a tone-disable flag while the condition lasts.
// - Global mask, bit 5 of first main control register, suppresses requests.
// - Main control bits 4 and 3 mask tone interrupts per canceller.
// - Control one: reinit 7, bypass 3, adapt off 2, reserved 1, ext delay 0.
// - Bypass passes data unchanged, zeroes coefficients and stops adaptation.
// - Extended delay in canceller A cascades the pair into one canceller.
// - Power-up rising edge resets both cancellers' registers over two frames.
// - Adaptation disable freezes coefficients while cancelling continues.
package echo_ctrl_pkg;
   localparam int NUM_GROUPS = 16;
   localparam int NUM_CHANS = 32;
   localparam int FIFO_DEPTH = 32;

   // Host address map
   localparam logic [10:0] MAIN_CTRL_BASE = 11'h400;
   localparam logic [10:0] IRQ_FIFO_ADDR = 11'h410;
   localparam logic [4:0] OFF_CTRL_ONE = 5'h00;
   localparam logic [4:0] OFF_STATUS = 5'h02;

   // Canceller control one fields
   localparam int CTRL_REINIT_BIT = 7;
   localparam int CTRL_BYPASS_BIT = 3;
   localparam int CTRL_ADP_DIS_BIT = 2;
   localparam int CTRL_EXT_DLY_BIT = 0;
   localparam logic [7:0] CTRL_A_RESET = 8'h00;
   localparam logic [7:0] CTRL_B_RESET = 8'h02;
   localparam logic [7:0] CTRL_A_WMASK = 8'hFD;
   localparam logic [7:0] CTRL_B_WMASK = 8'hFC;

   // Main control fields
   localparam int MAIN_GROUP_POWER_UP_BIT = 0;
   localparam int MAIN_GMASK_BIT = 5;
   localparam int MAIN_MASK_B_BIT = 4;
   localparam int MAIN_MASK_A_BIT = 3;
   localparam logic [7:0] MAIN_RESET = 8'h00;
   localparam logic [7:0] MAIN_WMASK_G0 = 8'h39;
   localparam logic [7:0] MAIN_WMASK = 8'h19;

   // Status fields
   localparam int STATUS_TONE_BIT = 0;
   localparam int STATUS_INIT_BIT = 1;

   localparam logic [7:0] IRQ_FIFO_EMPTY_CODE = 8'hFF;
   localparam logic [1:0] INIT_FRAMES = 2'h2;

   // Request pin high time after a FIFO read
   localparam int CLK_PERIOD_NS = 10;
   localparam int IRQ_GAP_NS = 30;
   localparam logic [1:0] IRQ_GAP_CYC = 2'((IRQ_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

   typedef enum logic [2:0] {
      IRQ_IDLE = 3'b001,
      IRQ_LOW = 3'b010,
      IRQ_GAP = 3'b100
   } irq_state_t;

   typedef struct packed {
      logic [4:0] chan;
      logic [7:0] rin;
      logic [7:0] sin;
   } pcm_word_t;

   typedef struct packed {
      logic csN;
      logic rdN;
      logic wrN;
      logic [10:0] addr;
      logic [7:0] wdata;
   } host_bus_t;
endpackage : echo_ctrl_pkg

// *** rtl/irq_chan_fifo.sv ***
`timescale 1ns/1ps
`default_nettype none
module irq_chan_fifo
   import echo_ctrl_pkg::*;
(
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic push,
   input wire logic [4:0] pushChan,
   input wire logic pop,
   output logic [4:0] headChan,
   output logic empty,
   output logic full
);
   typedef struct packed {
      logic [FIFO_DEPTH-1:0][4:0] mem;
      logic [5:0] wp;
      logic [5:0] rp;
   } fifo_state_t;

   fifo_state_t st_reg;
   fifo_state_t st_next;

   assign empty = st_reg.wp == st_reg.rp;
   assign full = (st_reg.wp[4:0] == st_reg.rp[4:0]) && (st_reg.wp[5] != st_reg.rp[5]);
   assign headChan = st_reg.mem[st_reg.rp[4:0]];

   always_comb begin
      st_next = st_reg;
      if (push && !full) begin
         st_next.mem[st_reg.wp[4:0]] = pushChan;
         st_next.wp = st_reg.wp + 6'h01;
      end
      if (pop && !empty) begin
         st_next.rp = st_reg.rp + 6'h01;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   a_fifo_pop_order: assert property (@(posedge ref_clk) disable iff (rst)
      (pop && !empty) |=> st_reg.rp == $past(st_reg.rp) + 6'h01)
      else $error("fifo read did not remove the oldest entry");
endmodule : irq_chan_fifo
`default_nettype wire

// *** rtl/pcm_two_entry_buf.sv ***
`timescale 1ns/1ps
`default_nettype none
module pcm_two_entry_buf
   import echo_ctrl_pkg::*;
(
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic inValid,
   output logic inReady,
   input wire pcm_word_t inWord,
   output logic outValid,
   input wire logic outReady,
   output pcm_word_t outWord
);
   typedef struct packed {
      pcm_word_t [1:0] slot;
      logic [1:0] count;
   } buf_state_t;

   buf_state_t st_reg;
   buf_state_t st_next;
   logic take;
   logic give;

   assign inReady = st_reg.count != 2'h2;
   assign outValid = st_reg.count != 2'h0;
   assign outWord = st_reg.slot[0];
   assign take = inValid && inReady;
   assign give = outValid && outReady;

   always_comb begin
      st_next = st_reg;
      if (give) begin
         st_next.slot[0] = st_reg.slot[1];
      end
      if (take) begin
         st_next.slot[st_reg.count - {1'b0, give}] = inWord;
      end
      st_next.count = st_reg.count + {1'b0, take} - {1'b0, give};
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end
endmodule : pcm_two_entry_buf
`default_nettype wire

// *** rtl/echo_group_ctrl_irq.sv ***
`timescale 1ns/1ps
`default_nettype none
module echo_group_ctrl_irq
   import echo_ctrl_pkg::*;
(
   input wire logic ref_clk,
   input wire logic rst,
   input wire host_bus_t hostBus,
   output logic [7:0] hostDataOut,
   output logic hostDataOe,
   output logic irqN,
   input wire logic framePulse,
   input wire logic [NUM_CHANS-1:0] toneDetect,
   input wire logic pcmInValid,
   output logic pcmInReady,
   input wire pcm_word_t pcmIn,
   input wire pcm_word_t ecResult,
   output logic pcmOutValid,
   input wire logic pcmOutReady,
   output pcm_word_t pcmOut,
   output logic [NUM_GROUPS-1:0] groupPowerDown,
   output logic [NUM_CHANS-1:0] filterClear,
   output logic [NUM_CHANS-1:0] adaptFreeze,
   output logic [NUM_GROUPS-1:0] cascade
);
   typedef struct packed {
      logic [NUM_CHANS-1:0][7:0] ctrlOne;
      logic [NUM_GROUPS-1:0][7:0] mainCtrl;
      logic [NUM_CHANS-1:0][1:0] initCnt;
      logic [NUM_CHANS-1:0][1:0][15:0] hist;
      logic [NUM_CHANS-1:0] toneSeen;
      logic [NUM_CHANS-1:0] pending;
      logic rdPrev;
      logic wrPrev;
      logic [7:0] rdata;
      logic dataOe;
      irq_state_t irqState;
      logic [1:0] gapCnt;
      logic irqN;
   } ctrl_state_t;

   function automatic logic [7:0] ctrlDefault(input logic odd);
      return odd ? CTRL_B_RESET : CTRL_A_RESET;
   endfunction : ctrlDefault

   function automatic ctrl_state_t resetState();
      ctrl_state_t s;
      s = '0;
      for (int c = 0; c < NUM_CHANS; c++) begin
         s.ctrlOne[c] = ctrlDefault(c % 2 == 1);
      end
      for (int g = 0; g < NUM_GROUPS; g++) begin
         s.mainCtrl[g] = MAIN_RESET;
      end
      s.irqState = IRQ_IDLE;
      s.irqN = 1'b1;
      return s;
   endfunction : resetState

   function automatic logic [5:0] lowestSet(input logic [NUM_CHANS-1:0] v);
      logic [5:0] r;
      r = '0;
      for (int i = NUM_CHANS - 1; i >= 0; i--) begin
         if (v[i]) begin
            r = {1'b1, 5'(i)};
         end
      end
      return r;
   endfunction : lowestSet

   ctrl_state_t st_reg;
   ctrl_state_t st_next;

   logic rdAct;
   logic wrAct;
   logic rdStart;
   logic wrStart;
   logic isChanSpace;
   logic isMain;
   logic isFifo;
   logic [4:0] accChan;
   logic [4:0] accOff;
   logic [3:0] accGroup;
   logic fifoRead;
   logic gMask;
   logic [NUM_CHANS-1:0] toneEvent;
   logic [NUM_CHANS-1:0] toneMask;
   logic [NUM_CHANS-1:0] pathBypass;
   logic [5:0] pick;
   logic fifoPush;
   logic fifoEmpty;
   logic fifoFull;
   logic [4:0] fifoHead;
   logic bufInReady;
   pcm_word_t bufInWord;
   logic [7:0] mainWrite;

   assign rdAct = !hostBus.csN && !hostBus.rdN;
   assign wrAct = !hostBus.csN && !hostBus.wrN;
   assign rdStart = rdAct && !st_reg.rdPrev;
   assign wrStart = wrAct && !st_reg.wrPrev;
   assign isChanSpace = !hostBus.addr[10];
   assign isMain = hostBus.addr[10:4] == MAIN_CTRL_BASE[10:4];
   assign isFifo = hostBus.addr == IRQ_FIFO_ADDR;
   assign accChan = hostBus.addr[9:5];
   assign accOff = hostBus.addr[4:0];
   assign accGroup = hostBus.addr[3:0];
   assign fifoRead = rdStart && isFifo;
   assign gMask = st_reg.mainCtrl[0][MAIN_GMASK_BIT];
   assign toneEvent = toneDetect ^ st_reg.toneSeen;
   assign pick = lowestSet(st_reg.pending);
   assign fifoPush = pick[5] && !fifoFull;
   assign mainWrite = hostBus.wdata & ((accGroup == 4'h0) ? MAIN_WMASK_G0 : MAIN_WMASK);

   for (genvar c = 0; c < NUM_CHANS; c++) begin : g_chan
      localparam int GRP = c / 2;
      localparam int MASK_BIT = (c % 2 == 1) ? MAIN_MASK_B_BIT : MAIN_MASK_A_BIT;
      assign toneMask[c] = st_reg.mainCtrl[GRP][MASK_BIT];
      assign pathBypass[c] = !st_reg.mainCtrl[GRP][MAIN_GROUP_POWER_UP_BIT]
         || st_reg.ctrlOne[c][CTRL_BYPASS_BIT];
      assign filterClear[c] = st_reg.ctrlOne[c][CTRL_BYPASS_BIT]
         || (st_reg.initCnt[c] != 2'h0);
      assign adaptFreeze[c] = st_reg.ctrlOne[c][CTRL_ADP_DIS_BIT] || filterClear[c];
      if (c % 2 == 0) begin : g_group
         assign groupPowerDown[GRP] = !st_reg.mainCtrl[GRP][MAIN_GROUP_POWER_UP_BIT];
         assign cascade[GRP] = st_reg.ctrlOne[c][CTRL_EXT_DLY_BIT];
      end
   end

   // Bypassed channels emit the sample seen two frames ago
   always_comb begin
      bufInWord.chan = pcmIn.chan;
      if (pathBypass[pcmIn.chan]) begin
         {bufInWord.rin, bufInWord.sin} = st_reg.hist[pcmIn.chan][1];
      end else begin
         bufInWord.rin = ecResult.rin;
         bufInWord.sin = ecResult.sin;
      end
   end

   always_comb begin
      st_next = st_reg;
      st_next.rdPrev = rdAct;
      st_next.wrPrev = wrAct;
      st_next.dataOe = rdAct;
      st_next.toneSeen = toneDetect;

      // Set after clear, so a fresh event on the queued channel survives
      if (fifoPush) begin
         st_next.pending[pick[4:0]] = 1'b0;
      end
      st_next.pending = st_next.pending | (toneEvent & ~toneMask);

      // Initialisation holds defaults for two frames
      for (int c = 0; c < NUM_CHANS; c++) begin
         if (st_reg.initCnt[c] != 2'h0) begin
            st_next.ctrlOne[c] = ctrlDefault(c % 2 == 1);
            if (framePulse) begin
               st_next.initCnt[c] = st_reg.initCnt[c] - 2'h1;
            end
         end
      end

      if (wrStart) begin
         if (isChanSpace && accOff == OFF_CTRL_ONE && st_reg.initCnt[accChan] == 2'h0) begin
            if (hostBus.wdata[CTRL_REINIT_BIT]) begin
               st_next.initCnt[accChan] = INIT_FRAMES;
               st_next.ctrlOne[accChan] = ctrlDefault(accChan[0]);
            end else if (accChan[0]) begin
               st_next.ctrlOne[accChan] = (hostBus.wdata & CTRL_B_WMASK)
                  | CTRL_B_RESET;
            end else begin
               st_next.ctrlOne[accChan] = hostBus.wdata & CTRL_A_WMASK;
            end
         end
         if (isMain) begin
            if (!st_reg.mainCtrl[accGroup][MAIN_GROUP_POWER_UP_BIT] && mainWrite[MAIN_GROUP_POWER_UP_BIT]) begin
               st_next.initCnt[{accGroup, 1'b0}] = INIT_FRAMES;
               st_next.initCnt[{accGroup, 1'b1}] = INIT_FRAMES;
               st_next.ctrlOne[{accGroup, 1'b0}] = CTRL_A_RESET;
               st_next.ctrlOne[{accGroup, 1'b1}] = CTRL_B_RESET;
            end
            st_next.mainCtrl[accGroup] = mainWrite;
         end
      end

      if (rdStart) begin
         if (isChanSpace && accOff == OFF_CTRL_ONE) begin
            st_next.rdata = st_reg.ctrlOne[accChan];
         end else if (isChanSpace && accOff == OFF_STATUS) begin
            st_next.rdata = 8'h00;
            st_next.rdata[STATUS_TONE_BIT] = st_reg.toneSeen[accChan];
            st_next.rdata[STATUS_INIT_BIT] = st_reg.initCnt[accChan] != 2'h0;
         end else if (isMain) begin
            st_next.rdata = st_reg.mainCtrl[accGroup];
         end else if (isFifo) begin
            st_next.rdata = fifoEmpty ? IRQ_FIFO_EMPTY_CODE : {3'h0, fifoHead};
         end else begin
            st_next.rdata = 8'h00;
         end
      end

      if (pcmInValid && bufInReady) begin
         st_next.hist[pcmIn.chan][1] = st_reg.hist[pcmIn.chan][0];
         st_next.hist[pcmIn.chan][0] = {pcmIn.rin, pcmIn.sin};
      end

      unique case (st_reg.irqState)
         IRQ_IDLE: begin
            if (!fifoEmpty && !gMask) begin
               st_next.irqState = IRQ_LOW;
            end
         end
         IRQ_LOW: begin
            if (gMask) begin
               st_next.irqState = IRQ_IDLE;
            end
         end
         IRQ_GAP: begin
            if (st_reg.gapCnt == 2'h1) begin
               st_next.irqState = IRQ_IDLE;
            end else begin
               st_next.gapCnt = st_reg.gapCnt - 2'h1;
            end
         end
         default: begin
            st_next.irqState = IRQ_IDLE;
         end
      endcase
      // Any FIFO read forces the gap, so the pin never stays low on a popped entry
      if (fifoRead) begin
         st_next.irqState = IRQ_GAP;
         st_next.gapCnt = IRQ_GAP_CYC;
      end
      st_next.irqN = st_next.irqState != IRQ_LOW;
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         st_reg <= resetState();
      end else begin
         st_reg <= st_next;
      end
   end

   assign hostDataOut = st_reg.rdata;
   assign hostDataOe = st_reg.dataOe;
   assign irqN = st_reg.irqN;
   assign pcmInReady = bufInReady;

   irq_chan_fifo u_fifo (
      .ref_clk(ref_clk),
      .rst(rst),
      .push(fifoPush),
      .pushChan(pick[4:0]),
      .pop(fifoRead),
      .headChan(fifoHead),
      .empty(fifoEmpty),
      .full(fifoFull)
   );

   pcm_two_entry_buf u_buf (
      .ref_clk(ref_clk),
      .rst(rst),
      .inValid(pcmInValid),
      .inReady(bufInReady),
      .inWord(bufInWord),
      .outValid(pcmOutValid),
      .outReady(pcmOutReady),
      .outWord(pcmOut)
   );

   a_irq_high_read: assert property (@(posedge ref_clk) disable iff (rst)
      fifoRead |=> irqN [*3])
      else $error("request pin not high after fifo read");

   a_irq_low_again: assert property (@(posedge ref_clk) disable iff (rst)
      (!fifoEmpty && !gMask && !fifoRead) [*6] |-> !irqN)
      else $error("request pin not low with entries pending");

   a_gmask_quiet: assert property (@(posedge ref_clk) disable iff (rst)
      gMask |=> irqN)
      else $error("request pin low under global mask");

   a_tone_event_pend: assert property (@(posedge ref_clk) disable iff (rst)
      (toneEvent & ~toneMask) != '0
         |=> (st_reg.pending & $past(toneEvent & ~toneMask)) == $past(toneEvent & ~toneMask))
      else $error("tone edge not held pending");

   a_pend_to_fifo: assert property (@(posedge ref_clk) disable iff (rst)
      (st_reg.pending != '0 && !fifoFull) |=> !fifoEmpty)
      else $error("pending interrupt not queued");

   a_status_tone: assert property (@(posedge ref_clk) disable iff (rst)
      rdStart && isChanSpace && accOff == OFF_STATUS
         |=> hostDataOut[STATUS_TONE_BIT] == $past(st_reg.toneSeen[accChan]))
      else $error("status tone flag wrong");

   a_power_down_path: assert property (@(posedge ref_clk) disable iff (rst)
      wrStart && isMain && accGroup == 4'h0 && !hostBus.wdata[MAIN_GROUP_POWER_UP_BIT]
         |=> groupPowerDown[0] && pathBypass[0] && pathBypass[1])
      else $error("group zero not powered down");

   a_group_power_up_init: assert property (@(posedge ref_clk) disable iff (rst)
      wrStart && isMain && !st_reg.mainCtrl[accGroup][MAIN_GROUP_POWER_UP_BIT] && hostBus.wdata[0]
         |=> filterClear[{$past(accGroup), 1'b1}]
            && st_reg.ctrlOne[{$past(accGroup), 1'b1}] == CTRL_B_RESET)
      else $error("power up did not start initialisation");

   a_bypass_clear: assert property (@(posedge ref_clk) disable iff (rst)
      st_reg.ctrlOne[0][CTRL_BYPASS_BIT] |-> filterClear[0] && adaptFreeze[0] && pathBypass[0])
      else $error("bypass did not clear and freeze");

   a_fifo_empty_read: assert property (@(posedge ref_clk) disable iff (rst)
      fifoRead && fifoEmpty |=> hostDataOut == IRQ_FIFO_EMPTY_CODE)
      else $error("empty fifo read returned a channel");

   a_reserved_b: assert property (@(posedge ref_clk) disable iff (rst)
      st_reg.ctrlOne[1][1:0] == 2'b10 && st_reg.ctrlOne[0][1] == 1'b0)
      else $error("reserved control bits wrong");
endmodule : echo_group_ctrl_irq
`default_nettype wire

// *** test/host_cpu_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module host_cpu_model
   import echo_ctrl_pkg::*;
(
   input wire logic ref_clk,
   input wire logic [7:0] hostDataOut,
   input wire logic hostDataOe,
   output var host_bus_t hostBus
);
   initial begin
      hostBus = '{1'b1, 1'b1, 1'b1, 11'h7FF, 8'hFF};
   end

   // Address and data turn to their inverse once released
   task automatic wr(input logic [10:0] a, input logic [7:0] v);
      @(negedge ref_clk);
      hostBus = '{1'b0, 1'b1, 1'b0, a, v};
      @(negedge ref_clk);
      hostBus = '{1'b1, 1'b1, 1'b1, ~a, ~v};
      @(negedge ref_clk);
   endtask : wr

   task automatic rd(input logic [10:0] a, output logic [7:0] v);
      @(negedge ref_clk);
      hostBus = '{1'b0, 1'b0, 1'b1, a, 8'hA5};
      for (int n = 0; n < 8; n++) begin
         @(posedge ref_clk);
         if (hostDataOe === 1'b1) break;
      end
      v = hostDataOut;
      @(negedge ref_clk);
      hostBus = '{1'b1, 1'b1, 1'b1, ~a, 8'h5A};
      @(negedge ref_clk);
   endtask : rd
endmodule : host_cpu_model
`default_nettype wire

// *** test/tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin \
   compares++; \
   if ((g) !== (e)) begin \
      n_errors++; \
      $display("wrong value at %0t ns: got %0h expected %0h", $time, g, e); \
   end \
end
module tb_top
   import echo_ctrl_pkg::*;
;
   logic ref_clk = 1'b0;
   logic rst = 1'b1;
   host_bus_t hostBus;
   logic [7:0] hostDataOut;
   logic hostDataOe, irqN, framePulse, pcmInValid, pcmInReady, pcmOutValid, pcmOutReady;
   logic [NUM_CHANS-1:0] toneDetect, filterClear, adaptFreeze;
   logic [NUM_GROUPS-1:0] groupPowerDown, cascade;
   pcm_word_t pcmIn, ecResult, pcmOut, w;
   int n_errors = 0;
   int compares = 0;
   int cyc = 0;

   always #5 ref_clk = ~ref_clk;

   host_cpu_model u_host (.ref_clk(ref_clk), .hostDataOut(hostDataOut),
      .hostDataOe(hostDataOe), .hostBus(hostBus));

   echo_group_ctrl_irq u_dut (.ref_clk(ref_clk), .rst(rst), .hostBus(hostBus),
      .hostDataOut(hostDataOut), .hostDataOe(hostDataOe), .irqN(irqN),
      .framePulse(framePulse), .toneDetect(toneDetect), .pcmInValid(pcmInValid),
      .pcmInReady(pcmInReady), .pcmIn(pcmIn), .ecResult(ecResult),
      .pcmOutValid(pcmOutValid), .pcmOutReady(pcmOutReady), .pcmOut(pcmOut),
      .groupPowerDown(groupPowerDown), .filterClear(filterClear),
      .adaptFreeze(adaptFreeze), .cascade(cascade));

   task automatic test_done;
      $display("counts: %0d compares, %0d errors", compares, n_errors);
      if (n_errors == 0 && compares > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : test_done

   always @(posedge ref_clk) begin
      cyc++;
      if (cyc == 20000) begin
         n_errors++;
         test_done();
      end
   end

   task automatic chkRd(input logic [10:0] a, input logic [7:0] e, input logic [7:0] m);
      logic [7:0] v;
      u_host.rd(a, v);
      `CHK(v & m, e)
   endtask : chkRd

   task automatic frame;
      @(negedge ref_clk);
      framePulse = 1'b1;
      @(negedge ref_clk);
      framePulse = 1'b0;
   endtask : frame

   task automatic waitIrq;
      for (int n = 0; n < 20 && irqN !== 1'b0; n++) begin
         @(negedge ref_clk);
      end
   endtask : waitIrq

   task automatic push(input logic [4:0] c, input logic [7:0] r, s, er, es);
      @(negedge ref_clk);
      pcmInValid = 1'b1;
      pcmIn = '{c, r, s};
      ecResult = '{c, er, es};
      for (int n = 0; n < 8; n++) begin
         @(posedge ref_clk);
         if (pcmInReady === 1'b1) break;
      end
      @(negedge ref_clk);
      pcmInValid = 1'b0;
      pcmIn = '{~c, ~r, ~s};
   endtask : push

   task automatic pull(output pcm_word_t o);
      @(negedge ref_clk);
      pcmOutReady = 1'b1;
      for (int n = 0; n < 8; n++) begin
         @(posedge ref_clk);
         if (pcmOutValid === 1'b1) break;
      end
      o = pcmOut;
      @(negedge ref_clk);
      pcmOutReady = 1'b0;
   endtask : pull

   initial begin
      framePulse = 1'b0;
      toneDetect = '0;
      pcmInValid = 1'b0;
      pcmOutReady = 1'b0;
      pcmIn = '0;
      ecResult = '0;
      repeat (2) @(negedge ref_clk);
      rst = 1'b0;
      chkRd(11'h000, 8'h00, 8'hFF);
      chkRd(11'h020, 8'h02, 8'hFF);
      chkRd(11'h7F0, 8'h00, 8'hFF);
      `CHK(groupPowerDown, 16'hFFFF)
      `CHK(irqN, 1'b1)
      $display("test reset done");

      u_host.wr(MAIN_CTRL_BASE, 8'h01);
      `CHK(groupPowerDown[0], 1'b0)
      `CHK(filterClear[1:0], 2'h3)
      chkRd(11'h002, 8'h02, 8'h02);
      u_host.wr(11'h000, 8'h04);
      frame();
      frame();
      @(negedge ref_clk);
      `CHK(filterClear[1:0], 2'h0)
      chkRd(11'h000, 8'h00, 8'hFF);
      $display("test power up done");

      u_host.wr(11'h000, 8'h0F);
      chkRd(11'h000, 8'h0D, 8'hFF);
      `CHK({cascade[0], filterClear[0], adaptFreeze[0]}, 3'h7)
      u_host.wr(11'h020, 8'h7F);
      chkRd(11'h020, 8'h7E, 8'hFF);
      `CHK({filterClear[1], adaptFreeze[1]}, 2'h3)
      u_host.wr(11'h020, 8'h02);
      u_host.wr(11'h020, 8'h80);
      chkRd(11'h022, 8'h02, 8'h02);
      `CHK(filterClear[1], 1'b1)
      frame();
      frame();
      chkRd(11'h020, 8'h02, 8'hFF);
      u_host.wr(11'h000, 8'h04);
      `CHK({cascade[0], filterClear[0], adaptFreeze[0]}, 3'h1)
      u_host.wr(11'h000, 8'h08);
      frame();
      `CHK(filterClear[0], 1'b1)
      u_host.wr(11'h000, 8'h00);
      `CHK({filterClear[0], adaptFreeze[0]}, 2'h0)
      $display("test control done");

      @(negedge ref_clk);
      toneDetect[1] = 1'b1;
      waitIrq();
      `CHK(irqN, 1'b0)
      chkRd(IRQ_FIFO_ADDR, 8'h01, 8'hFF);
      `CHK(irqN, 1'b1)
      chkRd(11'h022, 8'h01, 8'h01);
      @(negedge ref_clk);
      toneDetect[1:0] = 2'h1;
      waitIrq();
      chkRd(IRQ_FIFO_ADDR, 8'h00, 8'hFF);
      `CHK(irqN, 1'b1)
      waitIrq();
      `CHK(irqN, 1'b0)
      chkRd(IRQ_FIFO_ADDR, 8'h01, 8'hFF);
      chkRd(IRQ_FIFO_ADDR, IRQ_FIFO_EMPTY_CODE, 8'hFF);
      chkRd(11'h022, 8'h00, 8'h01);
      $display("test interrupt done");

      u_host.wr(MAIN_CTRL_BASE, 8'h09);
      @(negedge ref_clk);
      toneDetect[0] = 1'b0;
      repeat (10) @(negedge ref_clk);
      `CHK(irqN, 1'b1)
      chkRd(IRQ_FIFO_ADDR, IRQ_FIFO_EMPTY_CODE, 8'hFF);
      u_host.wr(MAIN_CTRL_BASE, 8'h21);
      @(negedge ref_clk);
      toneDetect[1] = 1'b1;
      repeat (10) @(negedge ref_clk);
      `CHK(irqN, 1'b1)
      u_host.wr(MAIN_CTRL_BASE, 8'h01);
      waitIrq();
      `CHK(irqN, 1'b0)
      chkRd(IRQ_FIFO_ADDR, 8'h01, 8'hFF);
      u_host.wr(11'h401, 8'h3E);
      chkRd(11'h401, 8'h18, 8'hFF);
      $display("test mask done");

      // Group 1 is still powered down
      for (int i = 0; i < 3; i++) begin
         push(5'h02, 8'h10 + 8'(i), 8'h20 + 8'(i), 8'hEE, 8'hEE);
         pull(w);
      end
      `CHK({w.rin, w.sin}, 16'h1020)
      push(5'h00, 8'h01, 8'h02, 8'h03, 8'h04);
      push(5'h00, 8'h05, 8'h06, 8'h07, 8'h08);
      @(negedge ref_clk);
      `CHK({pcmInReady, pcmOutValid}, 2'h1)
      pull(w);
      `CHK({w.rin, w.sin}, 16'h0304)
      pull(w);
      `CHK({w.rin, w.sin}, 16'h0708)
      `CHK(pcmOutValid, 1'b0)
      $display("test stream done");

      u_host.wr(MAIN_CTRL_BASE, 8'h00);
      `CHK(groupPowerDown[0], 1'b1)
      $display("test power down done");
      test_done();
   end
endmodule : tb_top
`default_nettype wire
